// File: rtl/dbg_auth_pkg.sv
// Purpose: Shared constants and types for the debug authentication and status/control block.
// Assumes: Coprocessor moves arrive already decoded into their encoding fields.
// Notes: All encodings, bit positions and reset values live here; the assertions and the bench repeat bit positions as literals.

package dbg_auth_pkg;

   localparam logic [3:0]  DEBUG_COPROC    = 4'hE;
   localparam logic [2:0]  AUTH_OPC1       = 3'h0;
   localparam logic [2:0]  AUTH_OPC2       = 3'h6;
   localparam logic [3:0]  AUTH_CRN        = 4'h7;
   localparam logic [3:0]  AUTH_CRM        = 4'hE;
   localparam logic [2:0]  CTRL_OPC1       = 3'h0;
   localparam logic [2:0]  CTRL_OPC2       = 3'h2;
   localparam logic [3:0]  CTRL_CRN        = 4'h0;
   localparam logic [3:0]  CTRL_CRM        = 4'h2;

   localparam int          HYP_NINV_LO     = 10;
   localparam int          HYP_INV_LO      = 8;
   localparam int          SEC_NINV_LO     = 6;
   localparam int          SEC_INV_LO      = 4;
   localparam int          OPEN_NINV_LO    = 2;
   localparam int          OPEN_INV_LO     = 0;
   localparam logic [1:0]  FIELD_ABSENT    = 2'h0;
   localparam logic [1:0]  FIELD_OFF       = 2'h2;
   localparam logic [1:0]  FIELD_ON        = 2'h3;

   localparam int          RXF_BIT         = 30;
   localparam int          TXF_BIT         = 29;
   localparam int          RX_OVR_BIT      = 27;
   localparam int          TX_UND_BIT      = 26;
   localparam int          IRQ_OFF_LO      = 22;
   localparam int          ACC_TRAP_BIT    = 21;
   localparam int          WORLD_BIT       = 18;
   localparam int          SPNID_BIT       = 17;
   localparam int          SPID_BIT        = 16;
   localparam int          MDBG_BIT        = 15;
   localparam int          HALT_EN_BIT     = 14;
   localparam int          UCT_BIT         = 12;
   localparam int          ERR_BIT         = 6;
   localparam int          CAUSE_LO        = 2;

   localparam logic        WORLD_VALUE     = 1'b1;
   localparam logic        SPNID_VALUE     = 1'b0;
   localparam logic        SPID_VALUE      = 1'b0;
   localparam logic        MDBG_RESET      = 1'b0;
   localparam logic        UCT_RESET       = 1'b0;
   localparam logic [3:0]  CAUSE_RESET     = 4'h0;

   localparam logic [3:0]  CAUSE_BREAK     = 4'h1;
   localparam logic [3:0]  CAUSE_SOFT_BRK  = 4'h3;
   localparam logic [3:0]  CAUSE_VCATCH    = 4'h5;
   localparam logic [3:0]  CAUSE_WATCH     = 4'hA;

   typedef enum logic [1:0] {
      EL_USER = 2'h0,
      EL_KERN = 2'h1,
      EL_HYP  = 2'h2
   } el_t;

   typedef enum logic [2:0] {
      CR_STATUS = 3'h0,
      CR_RX     = 3'h1,
      CR_TX     = 3'h2,
      CR_ID     = 3'h3,
      CR_SELF   = 3'h4,
      CR_ROM    = 3'h5
   } comms_reg_t;

   typedef enum logic [1:0] {
      AF_MOVE   = 2'h0,
      AF_LDST   = 2'h1,
      AF_DOUBLE = 2'h2
   } access_form_t;

   typedef struct packed {
      logic       rxf;
      logic       txf;
      logic       rx_ovr;
      logic       tx_und;
      logic [1:0] irq_off;
      logic       acc_trap;
      logic       halt_en;
      logic       err;
   } mirror_t;

endpackage : dbg_auth_pkg

// File: rtl/auth_if.sv
// Purpose: Carries the external debug enables to the authentication composer and its value back.
// Assumes: All members are levels sampled in the clk_sys domain.
// Notes: The user modport drives the enables; the composer drives the value.

`timescale 1ns/1ns
`default_nettype none

interface auth_if;
   logic        el2_present;
   logic        hyp_inv_en;
   logic        hyp_ninv_en;
   logic        inv_en;
   logic        ninv_en;
   logic [31:0] value;

   modport composer (input el2_present, hyp_inv_en, hyp_ninv_en, inv_en, ninv_en,
                     output value);
   modport user     (output el2_present, hyp_inv_en, hyp_ninv_en, inv_en, ninv_en,
                     input value);
endinterface : auth_if

`default_nettype wire

// File: rtl/auth_status_comp.sv
// Purpose: Composes the read-only authentication status word from the enable inputs.
// Assumes: Purely combinational; the caller registers the value before it leaves the block.
// Notes: Reserved and secure fields are hard zeros.

`timescale 1ns/1ns
`default_nettype none

module auth_status_comp (
   auth_if.composer a
);
   import dbg_auth_pkg::*;

   function automatic logic [1:0] field_code(input logic present, input logic enabled);
      field_code = !present ? FIELD_ABSENT : (enabled ? FIELD_ON : FIELD_OFF);
   endfunction : field_code

   always_comb begin
      a.value = 32'h0000_0000;
      a.value[HYP_NINV_LO +: 2] = field_code(a.el2_present, a.hyp_ninv_en);
      a.value[HYP_INV_LO +: 2] = field_code(a.el2_present, a.hyp_inv_en);
      a.value[SEC_NINV_LO +: 2] = FIELD_ABSENT;
      a.value[SEC_INV_LO +: 2] = FIELD_ABSENT;
      a.value[OPEN_NINV_LO +: 2] = field_code(1'b1, a.ninv_en);
      a.value[OPEN_INV_LO +: 2] = field_code(1'b1, a.inv_en);
   end

endmodule : auth_status_comp

`default_nettype wire

// File: rtl/debug_auth_status_ctrl.sv
// Purpose: Authentication status and outer-view debug status/control registers behind coprocessor moves.
// Assumes: One move per request, all inputs synchronous to clk_sys; ce low freezes all state.
// Notes: Every request taken while ce is high is answered one cycle later with done, possibly marked refused or trapped.

`timescale 1ns/1ns
`default_nettype none

module debug_auth_status_ctrl (
   input  wire logic                       clk_sys,
   input  wire logic                       rst_n,
   input  wire logic                       ce,
   input  wire logic                       el2_present,
   input  wire logic                       ext_hyp_inv_en,
   input  wire logic                       ext_hyp_ninv_en,
   input  wire logic                       ext_inv_en,
   input  wire logic                       ext_ninv_en,
   input  wire logic                       debug_access_trap,
   input  wire logic                       cp_valid,
   input  wire logic                       cp_write,
   input  wire logic [3:0]                 cp_coproc,
   input  wire logic [2:0]                 cp_opc1,
   input  wire logic [2:0]                 cp_opc2,
   input  wire logic [3:0]                 cp_crn,
   input  wire logic [3:0]                 cp_crm,
   input  wire dbg_auth_pkg::el_t          cp_el,
   input  wire logic [31:0]                cp_wdata,
   output logic                            cp_done,
   output logic [31:0]                     cp_rdata,
   output logic                            cp_undef,
   output logic                            cp_hyp_trap,
   input  wire logic                       os_lock_bit,
   input  wire dbg_auth_pkg::mirror_t      ext_status,
   output logic                            mirror_wr,
   output dbg_auth_pkg::mirror_t           mirror_wdata,
   input  wire logic                       debug_exc_take,
   input  wire logic [3:0]                 debug_exc_cause,
   output logic                            monitor_debug_enable,
   output logic                            user_comms_trap,
   input  wire logic                       comms_valid,
   input  wire dbg_auth_pkg::comms_reg_t   comms_reg,
   input  wire dbg_auth_pkg::access_form_t comms_form,
   input  wire dbg_auth_pkg::el_t          comms_el,
   input  wire logic                       debug_state,
   output logic                            comms_trap
);
   import dbg_auth_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Decode and access checks.

   function automatic logic enc_match(input logic [2:0] o1, input logic [2:0] o2,
                                      input logic [3:0] n, input logic [3:0] m);
      enc_match = (cp_coproc == DEBUG_COPROC) && (cp_opc1 == o1) && (cp_opc2 == o2)
                  && (cp_crn == n) && (cp_crm == m);
   endfunction : enc_match

   auth_if auth ();

   logic        hit_auth;
   logic        hit_ctrl;
   logic        take;
   logic        refuse;
   logic        hyp_trap;
   logic        ctrl_write;
   logic [3:0]  entry_cause;
   logic        last_auth;
   logic        last_ctrl;
   logic [31:0] ctrl_view;

   assign auth.el2_present = el2_present;
   assign auth.hyp_inv_en  = ext_hyp_inv_en;
   assign auth.hyp_ninv_en = ext_hyp_ninv_en;
   assign auth.inv_en      = ext_inv_en;
   assign auth.ninv_en     = ext_ninv_en;

   auth_status_comp u_auth (
      .a (auth.composer)
   );

   assign take     = cp_valid && ce;
   assign hit_auth = enc_match(AUTH_OPC1, AUTH_OPC2, AUTH_CRN, AUTH_CRM);
   assign hit_ctrl = enc_match(CTRL_OPC1, CTRL_OPC2, CTRL_CRN, CTRL_CRM);

   // Unknown encodings, EL0 and writes to the read-only word are refused as undefined.
   assign refuse   = !(hit_auth || hit_ctrl) || (cp_el == EL_USER)
                     || (hit_auth && cp_write);
   assign hyp_trap = !refuse && (cp_el == EL_KERN) && el2_present
                     && debug_access_trap;
   assign ctrl_write = take && hit_ctrl && cp_write && !refuse && !hyp_trap;

   ////////////////////////////////////////////////////////////////////////////////
   // Outer view of the status/control word.

   always_comb begin
      ctrl_view = 32'h0000_0000;
      if (os_lock_bit) begin
         ctrl_view[RXF_BIT]          = ext_status.rxf;
         ctrl_view[TXF_BIT]          = ext_status.txf;
         ctrl_view[RX_OVR_BIT]       = ext_status.rx_ovr;
         ctrl_view[TX_UND_BIT]       = ext_status.tx_und;
         ctrl_view[IRQ_OFF_LO +: 2]  = ext_status.irq_off;
         ctrl_view[ACC_TRAP_BIT]     = ext_status.acc_trap;
         ctrl_view[HALT_EN_BIT]      = ext_status.halt_en;
         ctrl_view[ERR_BIT]          = ext_status.err;
      end
      ctrl_view[WORLD_BIT]           = WORLD_VALUE;
      ctrl_view[SPNID_BIT]           = SPNID_VALUE;
      ctrl_view[SPID_BIT]            = SPID_VALUE;
      ctrl_view[MDBG_BIT]            = monitor_debug_enable;
      ctrl_view[UCT_BIT]             = user_comms_trap;
      ctrl_view[CAUSE_LO +: 4]       = entry_cause;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Answer path.

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cp_done     <= 1'b0;
         cp_undef    <= 1'b0;
         cp_hyp_trap <= 1'b0;
         cp_rdata    <= 32'h0000_0000;
         last_auth   <= 1'b0;
         last_ctrl   <= 1'b0;
      end else if (ce) begin
         cp_done     <= cp_valid;
         cp_undef    <= cp_valid && refuse;
         cp_hyp_trap <= cp_valid && hyp_trap;
         last_auth   <= cp_valid && hit_auth && !refuse && !hyp_trap;
         last_ctrl   <= cp_valid && hit_ctrl && !refuse && !hyp_trap && !cp_write;
         if (cp_valid && !cp_write && !refuse && !hyp_trap) begin
            cp_rdata <= hit_auth ? auth.value : ctrl_view;
         end else if (cp_valid) begin
            cp_rdata <= 32'h0000_0000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Software-owned control bits.

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         monitor_debug_enable <= MDBG_RESET;
         user_comms_trap      <= UCT_RESET;
      end else if (ctrl_write) begin
         monitor_debug_enable <= cp_wdata[MDBG_BIT];
         user_comms_trap      <= cp_wdata[UCT_BIT];
      end
   end

   // A debug exception in the same cycle as a software write keeps its cause.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         entry_cause <= CAUSE_RESET;
      end else if (ce && debug_exc_take) begin
         entry_cause <= debug_exc_cause;
      end else if (ctrl_write) begin
         entry_cause <= cp_wdata[CAUSE_LO +: 4];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Mirror write-through to the external status register, only while locked.

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         mirror_wr    <= 1'b0;
         mirror_wdata <= '0;
      end else if (ce) begin
         mirror_wr <= ctrl_write && os_lock_bit;
         if (ctrl_write && os_lock_bit) begin
            mirror_wdata.rxf      <= cp_wdata[RXF_BIT];
            mirror_wdata.txf      <= cp_wdata[TXF_BIT];
            mirror_wdata.rx_ovr   <= cp_wdata[RX_OVR_BIT];
            mirror_wdata.tx_und   <= cp_wdata[TX_UND_BIT];
            mirror_wdata.irq_off  <= cp_wdata[IRQ_OFF_LO +: 2];
            mirror_wdata.acc_trap <= cp_wdata[ACC_TRAP_BIT];
            mirror_wdata.halt_en  <= cp_wdata[HALT_EN_BIT];
            mirror_wdata.err      <= cp_wdata[ERR_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // User comms-channel trap; the access form does not matter.

   logic data_reg;

   assign data_reg   = (comms_reg == CR_RX) || (comms_reg == CR_TX);
   assign comms_trap = comms_valid && (comms_el == EL_USER) && user_comms_trap
                       && (comms_form inside {AF_MOVE, AF_LDST, AF_DOUBLE})
                       && !(debug_state && data_reg);

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   a_el0_refused: assert property (take && cp_el == EL_USER |=> cp_done && cp_undef)
      else $error("EL0 move was not refused");
   a_done_exact: assert property (ce && !cp_valid |=> !cp_done)
      else $error("Answer without a taken move");
   a_ctrl_hyp_trap: assert property (
         take && hit_ctrl && cp_el == EL_KERN && el2_present && debug_access_trap
         |=> cp_hyp_trap && !cp_undef)
      else $error("EL1 status/control access did not trap to Hyp");
   a_auth_hyp_trap: assert property (
         take && hit_auth && !cp_write && cp_el == EL_KERN && el2_present && debug_access_trap
         |=> cp_hyp_trap)
      else $error("EL1 authentication read did not trap to Hyp");
   a_refused_inert: assert property (
         take && (refuse || hyp_trap)
         |=> $stable(monitor_debug_enable) && $stable(user_comms_trap))
      else $error("Refused or trapped move changed control bits");
   a_auth_fixed_zero: assert property (
         take && hit_auth && !refuse && !hyp_trap
         |=> cp_rdata[31:12] == 20'h0 && cp_rdata[7:4] == 4'h0)
      else $error("Authentication reserved or secure fields not zero");
   a_auth_el2_bits: assert property (
         take && hit_auth && !refuse && !hyp_trap
         |=> ($past(el2_present) ? (cp_rdata[11] && cp_rdata[9]) : (cp_rdata[11:8] == 4'h0)))
      else $error("Authentication hyp fields wrong for EL2 presence");
   a_auth_hyp_enable: assert property (
         take && hit_auth && !refuse && !hyp_trap && el2_present
         |=> cp_rdata[10] == $past(ext_hyp_ninv_en) && cp_rdata[8] == $past(ext_hyp_inv_en))
      else $error("Authentication hyp enable bits wrong");
   a_auth_open_world: assert property (
         take && hit_auth && !refuse && !hyp_trap
         |=> cp_rdata[3:0] == {1'b1, $past(ext_ninv_en), 1'b1, $past(ext_inv_en)})
      else $error("Authentication open-world fields wrong");
   a_world_bits: assert property (
         take && hit_ctrl && !cp_write && !refuse && !hyp_trap
         |=> cp_rdata[18:16] == 3'h4 && cp_rdata[31] == 1'b0)
      else $error("Status/control fixed bits read wrong");
   a_mirror_hidden: assert property (
         take && hit_ctrl && !cp_write && !refuse && !hyp_trap && !os_lock_bit
         |=> cp_rdata[30:29] == 2'h0)
      else $error("Mirror visible while unlocked");
   a_mirror_shown: assert property (
         take && hit_ctrl && !cp_write && !refuse && !hyp_trap && os_lock_bit
         |=> cp_rdata[HALT_EN_BIT] == $past(ext_status.halt_en))
      else $error("Mirror not reflected while locked");
   a_mirror_write: assert property (ctrl_write && !os_lock_bit |=> !mirror_wr)
      else $error("Mirror written while unlocked");
   a_mirror_through: assert property (ctrl_write && os_lock_bit |=> mirror_wr)
      else $error("Mirror not written while locked");
   a_ctrl_bits_write: assert property (
         ctrl_write |=> monitor_debug_enable == $past(cp_wdata[MDBG_BIT])
         && user_comms_trap == $past(cp_wdata[UCT_BIT]))
      else $error("Control bits not written");
   a_cause_capture: assert property (
         ce && debug_exc_take |=> entry_cause == $past(debug_exc_cause))
      else $error("Entry cause not captured");
   a_comms_user_trap: assert property (
         comms_valid && comms_el == EL_USER && user_comms_trap && comms_reg == CR_ID
         |-> comms_trap)
      else $error("User comms access not trapped");
   a_comms_kern_free: assert property (comms_el != EL_USER |-> !comms_trap)
      else $error("Comms access above EL0 trapped");
   a_debug_state_pass: assert property (debug_state && data_reg |-> !comms_trap)
      else $error("Data register trap not ignored in Debug state");

endmodule : debug_auth_status_ctrl

`default_nettype wire

// File: testbench/ext_status_model.sv
// Purpose: Model of the external debug status register behind the save/restore mirrors.
// Assumes: Only the block under test writes it, through mirror_wr pulses.
// Notes: Resets to an arbitrary pattern so that a leaked or missing mirror write shows up.

`timescale 1ns/1ns
`default_nettype none

module ext_status_model #(
   parameter logic [8:0] INIT = 9'h0A5
) (
   input  wire logic                  clk_sys,
   input  wire logic                  rst_n,
   input  wire logic                  mirror_wr,
   input  wire dbg_auth_pkg::mirror_t mirror_wdata,
   output dbg_auth_pkg::mirror_t      ext_status
);
   import dbg_auth_pkg::*;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ext_status <= mirror_t'(INIT);
      end else if (mirror_wr) begin
         ext_status <= mirror_wdata;
      end
   end
endmodule : ext_status_model

`default_nettype wire

// File: testbench/test_debug_auth_status_ctrl.sv
// Purpose: Self-checking bench for the debug authentication and status/control block.
// Assumes: Each taken move is answered one cycle later; comms_trap is combinational.
// Notes: The driver queues expected answers; a monitor consumes them on cp_done.

`timescale 1ns/1ns
`default_nettype none

module test_debug_auth_status_ctrl;
   import dbg_auth_pkg::*;
   localparam logic [8:0] EXT_INIT = 9'h0A5;
   typedef struct packed {
      logic [31:0] rd;
      logic        u;
      logic        h;
      logic        m;
      mirror_t     w;
   } ans_t;
   logic clk_sys, rst_n, ce, el2_present, ext_hyp_inv_en, ext_hyp_ninv_en, ext_inv_en;
   logic ext_ninv_en, debug_access_trap, cp_valid, cp_write, cp_done, cp_undef, cp_hyp_trap;
   logic os_lock_bit, mirror_wr, debug_exc_take, monitor_debug_enable, user_comms_trap;
   logic comms_valid, debug_state, comms_trap, mdbg, uct;
   logic [3:0]   cp_coproc, cp_crn, cp_crm, debug_exc_cause, cause;
   logic [2:0]   cp_opc1, cp_opc2;
   logic [31:0]  cp_wdata, cp_rdata;
   el_t          cp_el, comms_el;
   mirror_t      ext_status, mirror_wdata, mir;
   comms_reg_t   comms_reg;
   access_form_t comms_form;
   ans_t         exp_q[$];
   logic         cq[$];
   int           failures = 0;
   int           num_checks = 0;
   int           seed = 32'hE003F652;
   logic [3:0]   codes [4] = '{CAUSE_BREAK, CAUSE_SOFT_BRK, CAUSE_VCATCH, CAUSE_WATCH};

   debug_auth_status_ctrl dut (
      .clk_sys, .rst_n, .ce, .el2_present, .ext_hyp_inv_en, .ext_hyp_ninv_en, .ext_inv_en,
      .ext_ninv_en, .debug_access_trap, .cp_valid, .cp_write, .cp_coproc, .cp_opc1, .cp_opc2,
      .cp_crn, .cp_crm, .cp_el, .cp_wdata, .cp_done, .cp_rdata, .cp_undef, .cp_hyp_trap,
      .os_lock_bit, .ext_status, .mirror_wr, .mirror_wdata, .debug_exc_take, .debug_exc_cause,
      .monitor_debug_enable, .user_comms_trap, .comms_valid, .comms_reg, .comms_form,
      .comms_el, .debug_state, .comms_trap
   );
   ext_status_model #(.INIT(EXT_INIT)) partner (
      .clk_sys, .rst_n, .mirror_wr, .mirror_wdata, .ext_status
   );

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] auth_word();
      logic [31:0] w;
      w = 32'h0;
      if (el2_present) w[11:8] = {1'b1, ext_hyp_ninv_en, 1'b1, ext_hyp_inv_en};
      w[3:0] = {1'b1, ext_ninv_en, 1'b1, ext_inv_en};
      return w;
   endfunction : auth_word

   // Mirrors only show while the lock is held; bit 18 is a hard one.
   function automatic logic [31:0] ctrl_word();
      logic [31:0] w;
      w = 32'h0;
      w[WORLD_BIT] = 1'b1;
      w[MDBG_BIT] = mdbg;
      w[UCT_BIT] = uct;
      w[5:2] = cause;
      if (os_lock_bit) w = w | {1'b0, mir.rxf, mir.txf, 1'b0, mir.rx_ovr, mir.tx_und,
                                2'h0, mir.irq_off, mir.acc_trap, 6'h0, mir.halt_en, 7'h0,
                                mir.err, 6'h0};
      return w;
   endfunction : ctrl_word

   task automatic fail(input string msg);
      failures++;
      $display("ERROR %0t %s", $time, msg);
   endtask : fail

   task automatic cmp_bit(input logic got, input logic exp, input string msg);
      num_checks++;
      if (got !== exp) fail(msg);
   endtask : cmp_bit

   task automatic cmp_ans(input ans_t e);
      num_checks++;
      if ({cp_rdata, cp_undef, cp_hyp_trap, mirror_wr} !== {e.rd, e.u, e.h, e.m}) begin
         fail("answer mismatch");
      end else if (e.m && mirror_wdata !== e.w) begin
         fail("mirror data mismatch");
      end
   endtask : cmp_ans

   task automatic wrap_up();
      if (failures == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : wrap_up

   task automatic idle();
      @(posedge clk_sys);
      cp_valid <= 1'b0;
   endtask : idle

   task automatic do_reset();
      @(posedge clk_sys);
      rst_n <= 1'b0;
      repeat (6) @(posedge clk_sys);
      rst_n <= 1'b1;
      {mdbg, uct, cause} = 6'h0;
      mir = mirror_t'(EXT_INIT);
   endtask : do_reset

   // Sel 0 is the authentication word, 1 the control word, 2 an unmapped encoding.
   task automatic cp_op(input logic wr, input int sel, input el_t el, input logic [31:0] wd);
      logic [17:0] enc;
      ans_t a;
      @(posedge clk_sys);
      enc = (sel == 0) ? {DEBUG_COPROC, AUTH_OPC1, AUTH_OPC2, AUTH_CRN, AUTH_CRM}
          : (sel == 1) ? {DEBUG_COPROC, CTRL_OPC1, CTRL_OPC2, CTRL_CRN, CTRL_CRM}
          : {DEBUG_COPROC, AUTH_OPC1, AUTH_OPC2, AUTH_CRN, 4'hD};
      a = '0;
      a.u = (sel == 2) || (el == EL_USER) || (wr && sel == 0);
      a.h = !a.u && el == EL_KERN && el2_present && debug_access_trap;
      if (!a.u && !a.h && !wr) a.rd = (sel == 0) ? auth_word() : ctrl_word();
      if (!a.u && !a.h && wr) begin
         {mdbg, uct, cause} = {wd[MDBG_BIT], wd[UCT_BIT], wd[5:2]};
         a.m = os_lock_bit;
         if (os_lock_bit) mir = {wd[30:29], wd[27:26], wd[23:21], wd[14], wd[6]};
         a.w = mir;
      end
      exp_q.push_back(a);
      {cp_valid, cp_write, cp_coproc, cp_opc1, cp_opc2, cp_crn, cp_crm, cp_wdata} <=
         {1'b1, wr, enc, wd};
      cp_el <= el;
   endtask : cp_op

   task automatic comms_run();
      for (int i = 0; i < 72; i++) begin
         @(posedge clk_sys);
         cp_valid <= 1'b0;
         comms_valid <= 1'b1;
         comms_reg <= comms_reg_t'(3'(i % 6));
         comms_form <= access_form_t'(2'(i / 6 % 3));
         comms_el <= (i / 18 % 2) ? EL_KERN : EL_USER;
         debug_state <= (i >= 36);
         cq.push_back(i / 18 % 2 == 0 && uct && !(i >= 36 && (i % 6 == 1 || i % 6 == 2)));
      end
      idle();
      comms_valid <= 1'b0;
   endtask : comms_run

   ////////////////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk_sys) begin
      if (cp_done === 1'b1) begin
         if (exp_q.size() == 0) fail("answer without request");
         else cmp_ans(exp_q.pop_front());
      end
      if (comms_valid === 1'b1 && cq.size() > 0) cmp_bit(comms_trap, cq.pop_front(), "comms trap");
   end

   initial begin
      #50000;
      fail("timeout");
      wrap_up();
   end

   initial begin
      logic [31:0] wd;
      {rst_n, ce, el2_present, ext_hyp_inv_en, ext_hyp_ninv_en, ext_inv_en, ext_ninv_en} = 7'h20;
      {debug_access_trap, cp_valid, cp_write, os_lock_bit, debug_exc_take} = 5'h0;
      {comms_valid, debug_state, cp_coproc, cp_opc1, cp_opc2, cp_crn, cp_crm} = '0;
      {debug_exc_cause, cp_wdata} = '0;
      {cp_el, comms_el, comms_reg, comms_form} = {EL_USER, EL_USER, CR_STATUS, AF_MOVE};
      do_reset();
      cmp_bit(monitor_debug_enable, 1'b0, "enable after reset");
      cmp_bit(user_comms_trap, 1'b0, "comms trap bit after reset");
      cp_op(1'b0, 1, EL_KERN, 32'h0);
      for (int v = 0; v < 32; v++) begin
         idle();
         {el2_present, ext_hyp_inv_en, ext_hyp_ninv_en, ext_inv_en, ext_ninv_en} <= 5'(v);
         cp_op(1'b0, 0, EL_HYP, 32'h0);
         cp_op(1'b1, 0, EL_KERN, $random(seed));
         cp_op(1'b0, 0, EL_USER, 32'h0);
      end
      for (int t = 0; t < 4; t++) begin
         idle();
         {el2_present, debug_access_trap} <= 2'(t);
         cp_op(1'b0, 0, EL_KERN, 32'h0);
         cp_op(1'b1, 1, EL_KERN, $random(seed));
         cp_op(1'b0, 1, EL_KERN, 32'h0);
         cp_op(1'b1, 1, EL_USER, $random(seed));
         cp_op(1'b0, 1, EL_HYP, 32'h0);
         cp_op(1'b0, 2, EL_KERN, 32'h0);
      end
      idle();
      {el2_present, debug_access_trap, os_lock_bit} <= 3'h5;
      for (int k = 0; k < 4; k++) begin
         cp_op(1'b1, 1, EL_KERN, $random(seed));
         idle();
         cp_op(1'b0, 1, EL_HYP, 32'h0);
      end
      idle();
      os_lock_bit <= 1'b0;
      cp_op(1'b1, 1, EL_KERN, 32'hFFFFFFFF);
      cp_op(1'b0, 1, EL_KERN, 32'h0);
      for (int k = 0; k < 4; k++) begin
         idle();
         {debug_exc_take, debug_exc_cause} <= {1'b1, codes[k]};
         cause = codes[k];
         @(posedge clk_sys);
         debug_exc_take <= 1'b0;
         cp_op(1'b0, 1, EL_KERN, 32'h0);
      end
      cp_op(1'b1, 1, EL_KERN, 32'h0000000C);
      {debug_exc_take, debug_exc_cause} <= {1'b1, CAUSE_WATCH};
      cause = CAUSE_WATCH;
      idle();
      debug_exc_take <= 1'b0;
      cp_op(1'b0, 1, EL_KERN, 32'h0);
      for (int u = 0; u < 2; u++) begin
         wd = $random(seed);
         cp_op(1'b1, 1, EL_KERN, (wd & 32'hFFFF6FFF) | (u ? 32'h9000 : 32'h0));
         comms_run();
      end
      cmp_bit(monitor_debug_enable, mdbg, "enable level");
      cmp_bit(user_comms_trap, uct, "comms trap level");
      repeat (2) @(posedge clk_sys);
      {ce, cp_valid, cp_write, cp_wdata} <= {2'h1, 1'b1, 32'h0};
      repeat (4) @(posedge clk_sys);
      {ce, cp_valid} <= 2'h2;
      cp_op(1'b0, 1, EL_KERN, 32'h0);
      idle();
      @(posedge clk_sys);
      do_reset();
      cp_op(1'b0, 1, EL_KERN, 32'h0);
      idle();
      repeat (3) @(posedge clk_sys);
      if (exp_q.size() != 0 || cq.size() != 0) fail("missing answer");
      wrap_up();
   end
endmodule : test_debug_auth_status_ctrl

`default_nettype wire
